/* File: hw/cpu_status_regs.vh */
// Constants for the core status and operand register block.
// Assumes inclusion by the status block, its program counter unit, the checker and the bench.
`ifndef CPU_STATUS_REGS_VH
`define CPU_STATUS_REGS_VH
// ================================================================
// Special-function addresses
`define SFR_STATUS_ADDR 8'hd0
`define SFR_PRIMARY_ADDR 8'he0
`define SFR_SECOND_ADDR 8'hf0
// ================================================================
// Status word bit positions
`define ST_CARRY 7
`define ST_NIBBLE 6
`define ST_USER0 5
`define ST_BANK_HI 4
`define ST_BANK_LO 3
`define ST_OVF 2
`define ST_USER1 1
`define ST_PARITY 0
// ================================================================
// Reset values
`define STATUS_RESET 8'h00
`define PRIMARY_RESET 8'h00
`define SECOND_RESET 8'h00
// ================================================================
// Timing: core clocks per machine cycle
`define CLKS_PER_MCYCLE 2
// ================================================================
// ALU operation codes
`define OP_NONE 5'h00
`define OP_ADD 5'h01
`define OP_SUM_WITH_CARRY 5'h02
`define OP_MINUS_WITH_BORROW 5'h03
`define OP_INC 5'h04
`define OP_DEC 5'h05
`define OP_BCD 5'h06
`define OP_MUL 5'h07
`define OP_DIV 5'h08
`define OP_AND 5'h09
`define OP_OR 5'h0a
`define OP_XOR 5'h0b
`define OP_CLR 5'h0c
`define OP_CPL 5'h0d
`define OP_RL 5'h0e
`define OP_RLC 5'h0f
`define OP_RR 5'h10
`define OP_RRC 5'h11
`define OP_SWAP 5'h12
`define OP_MOV 5'h13
`define OP_CLRC 5'h14
`define OP_SETC 5'h15
`define OP_CPLC 5'h16
`define OP_ANDC 5'h17
`define OP_ORC 5'h18
`define OP_MOVC 5'h19
// ================================================================
// Operand source select
`define SRC_DIRECT 3'h0
`define SRC_INDIRECT 3'h1
`define SRC_REG 3'h2
`define SRC_IMM 3'h3
`define SRC_PRIMARY 3'h4
`define SRC_SECOND 3'h5
// ================================================================
// Program counter actions
`define PC_SEQ 3'h0
`define PC_REL 3'h1
`define PC_LONG 3'h2
`define PC_PAGE 3'h3
`define PC_INDEX 3'h4
`define PC_RET 3'h5
`endif

/* File: hw/cpu_pc_unit.v */
// Program counter target calculation for jumps, calls and returns.
// Assumes the caller supplies stack return address and pointer values.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_regs.vh"
module cpu_pc_unit (
   input wire [15:0] pcNow,
   input wire [2:0] pcAction,
   input wire [7:0] relDisp,
   input wire [15:0] absTarget,
   input wire [10:0] pageTarget,
   input wire [15:0] dataPtr16,
   input wire [7:0] primary,
   input wire [15:0] retAddr,
   output reg [15:0] pcNext
);
   // ================================================================
   // Target select
   always @* begin
      case (pcAction)
         `PC_REL: pcNext = pcNow + {{8{relDisp[7]}}, relDisp}; // RQ16 RQ20
         `PC_LONG: pcNext = absTarget; // RQ17 RQ19
         `PC_PAGE: pcNext = {pcNow[15:11], pageTarget}; // RQ17 RQ19
         `PC_INDEX: pcNext = dataPtr16 + {8'h00, primary}; // RQ18
         `PC_RET: pcNext = retAddr; // RQ19
         default: pcNext = pcNow;
      endcase
   end
endmodule
`default_nettype wire

/* File: hw/cpu_status_core.v */
// Status word, operand registers, addressing and ALU of the core.
// What this block does
// RQ1: Status word at d0 with fixed bits
// RQ2: Parity tracks accumulator every instruction cycle
// RQ3: Bank bits select register window 00-1f
// RQ4: Accumulator at e0, cleared on reset
// RQ5: Second operand at f0 for mul/div
// RQ6: Direct mode uses eight-bit address field
// RQ7: Indirect via register zero/one or pointer
// RQ8: Three-bit field picks bank register
// RQ9: Some opcodes target fixed registers
// RQ10: Immediate operand comes from instruction bytes
// RQ11: Indexed read: 16-bit base plus accumulator
// RQ12: Add, carry add, borrow subtract, inc, dec
// RQ13: And/or/xor plus seven accumulator operations
// RQ14: Moves between accumulator and internal locations
// RQ15: No external data memory access
// RQ16: Short jump uses signed byte displacement
// RQ17: Long jump 16-bit, page jump 11-bit
// RQ18: Indexed jump: pointer plus accumulator
// RQ19: Page and long calls, two returns
// RQ20: Conditional jumps use relative displacement
// RQ21: Bit instructions reach direct and SFR bits
// RQ22: Carry boolean logic, bit set/clear/test
// RQ23: Machine cycle is two core clocks
// RQ24: Flag effects per arithmetic instruction
// RQ25: Hardware parity beats software status write
// Assumes a sequencer that presents decoded operations and
// internal memory that answers reads combinationally.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_regs.vh"
module cpu_status_core (
   input wire clk,
   input wire rst_b,
   input wire timerReset,
   input wire opValid,
   input wire [4:0] aluOp,
   input wire [2:0] srcSel,
   input wire dstPrimary,
   input wire [7:0] directAddr,
   input wire [7:0] immData,
   input wire [2:0] regField,
   input wire indirectSel,
   input wire usePtrIndirect,
   input wire [7:0] bitAddr,
   input wire bitInvert,
   input wire [7:0] memRdata,
   input wire sfrWe,
   input wire [7:0] sfrAddr,
   input wire [7:0] sfrWdata,
   input wire [15:0] pcNow,
   input wire [2:0] pcAction,
   input wire [7:0] relDisp,
   input wire [15:0] absTarget,
   input wire [10:0] pageTarget,
   input wire [15:0] dataPtr16,
   input wire [15:0] retAddr,
   input wire indexedFromPc,
   output reg [7:0] sfrRdata,
   output reg [7:0] memAddr,
   output reg [15:0] codeAddr,
   output reg [7:0] statusWord,
   output reg [7:0] primaryReg,
   output reg [7:0] secondReg,
   output wire [15:0] pcNext,
   output reg machineEdge,
   output reg bitValue
);
   // ================================================================
   // Reset synchroniser
   reg rstMeta_q;
   reg rstSync_q;
   wire rstAll;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   // Timer reset comes from logic on this clock, so no sync is needed
   assign rstAll = !rstSync_q || timerReset;

   // ================================================================
   // Helpers
   function parityOf;
      input [7:0] v;
      begin
         parityOf = ^v;
      end
   endfunction

   function [7:0] bankBase;
      input [1:0] bank;
      begin
         bankBase = {3'b000, bank, 3'b000};
      end
   endfunction

   // ================================================================
   // Machine cycle phase: one machine cycle per two clocks
   reg phase_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= 1'b0;
         machineEdge <= 1'b0;
      end else if (rstAll) begin
         phase_q <= 1'b0;
         machineEdge <= 1'b0;
      end else begin
         phase_q <= ~phase_q; // RQ23
         machineEdge <= phase_q; // RQ23
      end
   end
   wire opTake = opValid && phase_q;

   // ================================================================
   // Addressing
   wire [1:0] bank = {statusWord[`ST_BANK_HI], statusWord[`ST_BANK_LO]};
   always @* begin
      memAddr = directAddr; // RQ6
      case (srcSel)
         `SRC_REG: memAddr = bankBase(bank) | {5'h00, regField}; // RQ3 RQ8
         `SRC_INDIRECT: memAddr = bankBase(bank) | {7'h00, indirectSel}; // RQ7
         default: memAddr = directAddr;
      endcase
      // Indexed reads go to code space only; no external data path exists
      codeAddr = (indexedFromPc ? pcNow : dataPtr16) + {8'h00, primaryReg}; // RQ11 RQ15
      if (usePtrIndirect)
         codeAddr = dataPtr16; // RQ7
   end

   // Indirect mode: first fetched byte (register content) becomes address;
   // sequencer issues a second access with directAddr = memRdata.
   reg [7:0] operand;
   always @* begin
      case (srcSel)
         `SRC_IMM: operand = immData; // RQ10
         `SRC_PRIMARY: operand = primaryReg; // RQ9
         `SRC_SECOND: operand = secondReg; // RQ9
         default: operand = memRdata; // RQ6 RQ7 RQ8
      endcase
   end

   // Bit addressing: 00-7f map to bytes 20-2f, 80-ff to SFR bytes
   wire [7:0] bitByteAddr = bitAddr[7] ? {bitAddr[7:3], 3'b000}
                                      : {4'h2, bitAddr[6:3]};
   reg [7:0] bitByte;
   always @* begin
      case (bitByteAddr)
         `SFR_STATUS_ADDR: bitByte = statusWord;
         `SFR_PRIMARY_ADDR: bitByte = primaryReg;
         `SFR_SECOND_ADDR: bitByte = secondReg;
         default: bitByte = memRdata;
      endcase
      bitValue = bitByte[bitAddr[2:0]] ^ bitInvert; // RQ21 RQ22
   end

   // ================================================================
   // ALU
   reg [7:0] res;
   reg [7:0] bRes;
   reg cy;
   reg ac;
   reg ov;
   reg [8:0] sum;
   reg [4:0] nib;
   reg [15:0] prod;
   reg [8:0] bcd;
   always @* begin
      res = primaryReg;
      bRes = secondReg;
      cy = statusWord[`ST_CARRY];
      ac = statusWord[`ST_NIBBLE];
      ov = statusWord[`ST_OVF];
      sum = 9'h000;
      nib = 5'h00;
      prod = 16'h0000;
      bcd = 9'h000;
      case (aluOp)
         `OP_ADD, `OP_SUM_WITH_CARRY: begin
            sum = {1'b0, primaryReg} + {1'b0, operand}
                + {8'h00, (aluOp == `OP_SUM_WITH_CARRY) & cy}; // RQ12
            nib = {1'b0, primaryReg[3:0]} + {1'b0, operand[3:0]}
                + {4'h0, (aluOp == `OP_SUM_WITH_CARRY) & cy};
            res = sum[7:0];
            cy = sum[8]; // RQ24
            ac = nib[4]; // RQ24
            ov = (primaryReg[7] == operand[7]) && (res[7] != primaryReg[7]); // RQ24
         end
         `OP_MINUS_WITH_BORROW: begin
            sum = {1'b0, primaryReg} - {1'b0, operand} - {8'h00, cy}; // RQ12
            nib = {1'b0, primaryReg[3:0]} - {1'b0, operand[3:0]} - {4'h0, cy};
            res = sum[7:0];
            cy = sum[8]; // RQ24
            ac = nib[4]; // RQ24
            ov = (primaryReg[7] != operand[7]) && (res[7] != primaryReg[7]); // RQ24
         end
         `OP_INC: res = operand + 8'h01; // RQ12
         `OP_DEC: res = operand - 8'h01; // RQ12
         `OP_BCD: begin
            bcd = {1'b0, primaryReg};
            if (bcd[3:0] > 4'h9 || ac)
               bcd = bcd + 9'h006;
            if (bcd[7:4] > 4'h9 || cy || bcd[8])
               bcd = bcd + 9'h060;
            res = bcd[7:0]; // RQ12
            cy = cy | bcd[8];
         end
         `OP_MUL: begin
            prod = primaryReg * secondReg; // RQ5 RQ12
            res = prod[7:0];
            bRes = prod[15:8];
            cy = 1'b0; // RQ24
            ov = (prod[15:8] != 8'h00); // RQ24
         end
         `OP_DIV: begin
            cy = 1'b0; // RQ24
            // Divide by zero leaves both operands unchanged; flag it in overflow
            ov = (secondReg == 8'h00); // RQ24
            if (!ov) begin
               res = primaryReg / secondReg; // RQ5 RQ12
               bRes = primaryReg % secondReg;
            end
         end
         `OP_AND: res = primaryReg & operand; // RQ13
         `OP_OR: res = primaryReg | operand; // RQ13
         `OP_XOR: res = primaryReg ^ operand; // RQ13
         `OP_CLR: res = 8'h00; // RQ13
         `OP_CPL: res = ~primaryReg; // RQ13
         `OP_RL: res = {primaryReg[6:0], primaryReg[7]}; // RQ13
         `OP_RLC: begin
            res = {primaryReg[6:0], cy}; // RQ13
            cy = primaryReg[7];
         end
         `OP_RR: res = {primaryReg[0], primaryReg[7:1]}; // RQ13
         `OP_RRC: begin
            res = {cy, primaryReg[7:1]}; // RQ13
            cy = primaryReg[0];
         end
         `OP_SWAP: res = {primaryReg[3:0], primaryReg[7:4]}; // RQ13
         `OP_MOV: res = operand; // RQ14
         `OP_CLRC: cy = 1'b0; // RQ24
         `OP_SETC: cy = 1'b1; // RQ24
         `OP_CPLC: cy = ~cy; // RQ22
         `OP_ANDC: cy = cy & bitValue; // RQ22
         `OP_ORC: cy = cy | bitValue; // RQ22
         `OP_MOVC: cy = bitValue; // RQ22
         default: res = primaryReg;
      endcase
   end

   // ================================================================
   // Register update
   wire writesPrimary = opTake && dstPrimary && (aluOp != `OP_NONE)
                      && (aluOp < `OP_CLRC);
   wire writesSecond = opTake && (aluOp == `OP_MUL || aluOp == `OP_DIV);
   wire writesFlags = opTake && (aluOp != `OP_NONE);
   reg [7:0] status_d;
   reg [7:0] primary_d;
   always @* begin
      primary_d = primaryReg;
      if (sfrWe && sfrAddr == `SFR_PRIMARY_ADDR)
         primary_d = sfrWdata; // RQ4
      if (writesPrimary)
         primary_d = res; // RQ9 RQ14
      status_d = statusWord;
      if (sfrWe && sfrAddr == `SFR_STATUS_ADDR)
         status_d = sfrWdata; // RQ1
      if (writesFlags) begin
         status_d[`ST_CARRY] = cy;
         status_d[`ST_NIBBLE] = ac;
         status_d[`ST_OVF] = ov;
      end
      // Parity is a view of the accumulator, so any written value loses
      status_d[`ST_PARITY] = parityOf(primary_d); // RQ2 RQ25
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         statusWord <= `STATUS_RESET;
         primaryReg <= `PRIMARY_RESET;
         secondReg <= `SECOND_RESET;
      end else if (rstAll) begin
         statusWord <= `STATUS_RESET; // RQ1
         primaryReg <= `PRIMARY_RESET; // RQ4
         secondReg <= `SECOND_RESET; // RQ5
      end else begin
         statusWord <= status_d;
         primaryReg <= primary_d;
         if (writesSecond)
            secondReg <= bRes;
         else if (sfrWe && sfrAddr == `SFR_SECOND_ADDR)
            secondReg <= sfrWdata; // RQ5
      end
   end

   // ================================================================
   // Register read port
   always @* begin
      case (sfrAddr)
         `SFR_STATUS_ADDR: sfrRdata = statusWord; // RQ1
         `SFR_PRIMARY_ADDR: sfrRdata = primaryReg; // RQ4
         `SFR_SECOND_ADDR: sfrRdata = secondReg; // RQ5
         default: sfrRdata = 8'h00;
      endcase
   end

   // ================================================================
   // Program counter
   cpu_pc_unit pcUnit (
      .pcNow(pcNow),
      .pcAction(pcAction),
      .relDisp(relDisp),
      .absTarget(absTarget),
      .pageTarget(pageTarget),
      .dataPtr16(dataPtr16),
      .primary(primaryReg),
      .retAddr(retAddr),
      .pcNext(pcNext)
   );
endmodule
`default_nettype wire

/* File: tb/cpu_status_sva.sv */
// Checker for the core status block, bound to its top module.
// Assumes one clock domain and the design header on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_regs.vh"
module cpu_status_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic timerReset,
   input wire logic opValid,
   input wire logic [4:0] aluOp,
   input wire logic [2:0] srcSel,
   input wire logic [7:0] directAddr,
   input wire logic [2:0] regField,
   input wire logic usePtrIndirect,
   input wire logic sfrWe,
   input wire logic [15:0] pcNow,
   input wire logic [2:0] pcAction,
   input wire logic [7:0] relDisp,
   input wire logic [10:0] pageTarget,
   input wire logic [15:0] dataPtr16,
   input wire logic indexedFromPc,
   input wire logic [7:0] memAddr,
   input wire logic [15:0] codeAddr,
   input wire logic [7:0] statusWord,
   input wire logic [7:0] primaryReg,
   input wire logic [7:0] secondReg,
   input wire logic [15:0] pcNext,
   input wire logic machineEdge
);
   // ====
   // Internal reset lags the pin by two edges, so wait before judging
   logic [1:0] upQ;
   wire live = (upQ == 2'h3);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upQ <= 2'h0;
      end else if (!live) begin
         upQ <= upQ + 2'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ====
   // Two clocks of request always span exactly one taking edge
   sequence setcHeld;
      (live && opValid && aluOp == `OP_SETC && !sfrWe && !timerReset) [*2];
   endsequence
   sequence mulHeld;
      (live && opValid && aluOp == `OP_MUL && !sfrWe && !timerReset) [*2];
   endsequence
   // A timer reset restarts the phase, so only judge beats that run undisturbed
   a_machine_beat: assert property (live && machineEdge && !timerReset ##1 !timerReset |-> !machineEdge ##1 machineEdge)
      else $error("machine cycle is not two clocks");
   a_parity_track: assert property (live |-> statusWord[`ST_PARITY] == ^primaryReg)
      else $error("parity does not follow accumulator");
   a_bank_window: assert property (srcSel == `SRC_REG |->
      memAddr == {3'h0, statusWord[4:3], regField})
      else $error("register window wrong for bank");
   a_direct_field: assert property (srcSel == `SRC_DIRECT |-> memAddr == directAddr)
      else $error("direct address not used");
   a_ptr_code: assert property (usePtrIndirect |-> codeAddr == dataPtr16)
      else $error("pointer not on code address");
   a_index_code: assert property (aluOp == `OP_MOVC && !usePtrIndirect |->
      codeAddr == (indexedFromPc ? pcNow : dataPtr16) + primaryReg)
      else $error("indexed code address wrong");
   a_rel_jump: assert property (pcAction == `PC_REL |->
      pcNext == pcNow + {{8{relDisp[7]}}, relDisp})
      else $error("relative target wrong");
   a_page_jump: assert property (pcAction == `PC_PAGE |->
      pcNext == {pcNow[15:11], pageTarget})
      else $error("page target wrong");
   a_index_jump: assert property (pcAction == `PC_INDEX |->
      pcNext == dataPtr16 + primaryReg)
      else $error("indexed jump target wrong");
   a_timer_clear: assert property (live && timerReset |=>
      statusWord == 8'h00 && primaryReg == 8'h00 && secondReg == 8'h00)
      else $error("timer reset left a register set");
   a_setc_force: assert property (setcHeld |=> statusWord[`ST_CARRY])
      else $error("set carry did not set carry");
   a_mul_carry: assert property (mulHeld |=> !statusWord[`ST_CARRY])
      else $error("multiply left carry set");
endmodule
bind cpu_status_core cpu_status_sva cpu_status_sva_inst (.clk, .rst_b, .timerReset,
   .opValid, .aluOp, .srcSel, .directAddr, .regField, .usePtrIndirect, .sfrWe, .pcNow,
   .pcAction, .relDisp, .pageTarget, .dataPtr16, .indexedFromPc, .memAddr, .codeAddr,
   .statusWord, .primaryReg, .secondReg, .pcNext, .machineEdge);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the core status block.
// Assumes the design header on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_regs.vh"
module tb_top;
   logic clk, rst_b = 1'h0, timerReset = 1'h0, opValid = 1'h0, dstPrimary = 1'h1;
   logic indirectSel = 1'h0, usePtrIndirect = 1'h0, bitInvert = 1'h0, sfrWe = 1'h0;
   logic indexedFromPc = 1'h0;
   logic [4:0] aluOp = 5'h00;
   logic [2:0] srcSel = 3'h0, regField = 3'h0, pcAction = 3'h0;
   logic [7:0] directAddr = 8'h00, immData = 8'h00, bitAddr = 8'h00, memRdata = 8'h00;
   logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, relDisp = 8'h00;
   logic [15:0] pcNow = 16'h1234, absTarget = 16'hbeef, dataPtr16 = 16'h2000;
   logic [15:0] retAddr = 16'h4321;
   logic [10:0] pageTarget = 11'h7ff;
   wire [7:0] sfrRdata, memAddr, statusWord, primaryReg, secondReg;
   wire [15:0] codeAddr, pcNext;
   wire machineEdge, bitValue;
   int failCount = 0, checked = 0;
   cpu_status_core cpu_status_core_inst (.clk, .rst_b, .timerReset, .opValid, .aluOp,
      .srcSel, .dstPrimary, .directAddr, .immData, .regField, .indirectSel,
      .usePtrIndirect, .bitAddr, .bitInvert, .memRdata, .sfrWe, .sfrAddr, .sfrWdata,
      .pcNow, .pcAction, .relDisp, .absTarget, .pageTarget, .dataPtr16, .retAddr,
      .indexedFromPc, .sfrRdata, .memAddr, .codeAddr, .statusWord, .primaryReg,
      .secondReg, .pcNext, .machineEdge, .bitValue);
   // ====
   // Shared tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfrAddr <= a;
      sfrWdata <= d;
      sfrWe <= 1'h1;
      @(posedge clk);
      sfrWe <= 1'h0;
   endtask
   task automatic setAll(input logic [7:0] a, input logic [7:0] b, input logic [7:0] p);
      sfrWr(`SFR_PRIMARY_ADDR, a);
      sfrWr(`SFR_SECOND_ADDR, b);
      sfrWr(`SFR_STATUS_ADDR, p);
      #1;
   endtask
   // Held two clocks: the phase is hidden, and exactly one taking edge falls inside
   task automatic op(input logic [4:0] o, input logic [2:0] s, input logic [7:0] d);
      @(posedge clk);
      aluOp <= o;
      srcSel <= s;
      immData <= d;
      opValid <= 1'h1;
      repeat (2) @(posedge clk);
      opValid <= 1'h0;
      #1;
   endtask
   // ====
   // Scenarios
   task automatic tSfr;
      chk("status", statusWord, 16'h0000);
      chk("primary", primaryReg, 16'h0000);
      chk("second", secondReg, 16'h0000);
      setAll(8'h07, 8'h5a, 8'hfe);
      chk("status", statusWord, 16'h00ff);
      chk("second", secondReg, 16'h005a);
      sfrWr(8'h80, 8'h11);
      #1;
      chk("unmapped", sfrRdata, 16'h0000);
      @(posedge clk);
      sfrAddr <= `SFR_PRIMARY_ADDR;
      #1;
      chk("read primary", sfrRdata, 16'h0007);
   endtask
   task automatic tAddr;
      for (int b = 0; b < 4; b++) begin
         sfrWr(`SFR_STATUS_ADDR, 8'(b << 3));
         @(posedge clk);
         srcSel <= `SRC_REG;
         regField <= 3'(7 - b);
         #1;
         chk("bank reg", memAddr, 16'(b * 8 + 7 - b));
      end
      @(posedge clk);
      srcSel <= `SRC_DIRECT;
      directAddr <= 8'ha5;
      #1;
      chk("direct", memAddr, 16'h00a5);
      @(posedge clk);
      srcSel <= `SRC_INDIRECT;
      indirectSel <= 1'h1;
      #1;
      chk("indirect reg", memAddr, 16'h0019);
   endtask
   task automatic tLogic;
      logic [4:0] ops [13] = '{`OP_AND, `OP_OR, `OP_XOR, `OP_CLR, `OP_CPL, `OP_RL, `OP_RR,
         `OP_SWAP, `OP_RLC, `OP_RRC, `OP_INC, `OP_DEC, `OP_MOV};
      logic [7:0] res [13] = '{8'h06, 8'h9f, 8'h99, 8'h00, 8'h69, 8'h2d, 8'h4b, 8'h69,
         8'h2c, 8'h4b, 8'h97, 8'h95, 8'h0f};
      for (int i = 0; i < 13; i++) begin
         setAll(8'h96, 8'h00, 8'h00);
         // Increment and decrement act on the accumulator here
         op(ops[i], (i == 10 || i == 11) ? `SRC_PRIMARY : `SRC_IMM, 8'h0f);
         chk("acc result", primaryReg, {8'h00, res[i]});
      end
   endtask
   // Row: {src, op}, acc, second, status, imm, then expected acc, second, status
   task automatic tArith;
      logic [63:0] rows [8] = '{64'h617f000001800045, 64'h6300000001ff00c0,
         64'h620f008000100041, 64'ha710208000000204, 64'ha8640780000e0201,
         64'h7500000000000080, 64'h7400008000000000, 64'h669a000000000080};
      logic [63:0] r;
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         setAll(r[55:48], r[47:40], r[39:32]);
         op(r[60:56], r[63:61], r[31:24]);
         chk("acc", primaryReg, {8'h00, r[23:16]});
         chk("second", secondReg, {8'h00, r[15:8]});
         chk("flags", statusWord, {8'h00, r[7:0]});
      end
   endtask
   task automatic tJump;
      logic [2:0] act [6] = '{`PC_REL, `PC_REL, `PC_LONG, `PC_PAGE, `PC_INDEX, `PC_RET};
      logic [15:0] exp [6] = '{16'h11b4, 16'h12b3, 16'hbeef, 16'h17ff, 16'h2010, 16'h4321};
      setAll(8'h10, 8'h00, 8'h00);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         pcAction <= act[i];
         relDisp <= (i == 0) ? 8'h80 : 8'h7f;
         #1;
         chk("next pc", pcNext, exp[i]);
      end
      @(posedge clk);
      aluOp <= `OP_MOVC;
      indexedFromPc <= 1'h1;
      #1;
      chk("code pc", codeAddr, 16'h1244);
      @(posedge clk);
      indexedFromPc <= 1'h0;
      #1;
      chk("code ptr", codeAddr, 16'h2010);
      @(posedge clk);
      usePtrIndirect <= 1'h1;
      #1;
      chk("indirect ptr", codeAddr, 16'h2000);
   endtask
   task automatic tBit;
      setAll(8'h00, 8'h00, 8'h80);
      @(posedge clk);
      bitAddr <= 8'hd7;
      #1;
      chk("status bit", {15'h0000, bitValue}, 16'h0001);
      @(posedge clk);
      bitInvert <= 1'h1;
      #1;
      chk("inverted bit", {15'h0000, bitValue}, 16'h0000);
      @(posedge clk);
      bitInvert <= 1'h0;
      bitAddr <= 8'h03;
      memRdata <= 8'h08;
      #1;
      chk("memory bit", {15'h0000, bitValue}, 16'h0001);
      @(posedge clk);
      memRdata <= 8'h00;
      op(`OP_ANDC, `SRC_IMM, 8'h00);
      chk("and carry", statusWord, 16'h0000);
   endtask
   task automatic tTimer;
      setAll(8'h33, 8'h44, 8'h20);
      @(posedge clk);
      timerReset <= 1'h1;
      @(posedge clk);
      timerReset <= 1'h0;
      #1;
      chk("primary", primaryReg, 16'h0000);
      chk("second", secondReg, 16'h0000);
      chk("status", statusWord, 16'h0000);
   endtask
   // ====
   // Clock, sequence and watchdog
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      repeat (4) @(posedge clk);
      #1;
      tSfr;
      tAddr;
      tLogic;
      tArith;
      tJump;
      tBit;
      tTimer;
      testDone;
   end
   initial begin
      #100000;
      failCount++;
      testDone;
   end
endmodule
`default_nettype wire
